// [rtl/serdes_port_defines.vh]
// Register map, field positions, reset values and timing for the parallel port
`ifndef SERDES_PORT_DEFINES_VH
`define SERDES_PORT_DEFINES_VH
// Register byte offsets
`define REG_STATUS 8'h00
`define REG_CLEAR 8'h04
`define REG_IRQ_EN 8'h08
`define REG_MODE 8'h0c
// Status and enable field positions
`define ST_DEC_ERR_LSB 0
`define ST_OVERRUN_LSB 4
// Mode register field positions
`define MODE_CODEC_BIT 0
`define MODE_SYNC_BIT 1
// Reset values
`define STATUS_RESET 8'h00
`define IRQ_EN_RESET 8'h00
// Timing: system clock and generated receive clock periods
`define CLK_PERIOD_NS 4
`define RX_CLK_PERIOD_NS 48
// Code constants in their minus-disparity forms
`define K28_MINUS 6'h0f
`define ALT7_MINUS 4'h7
`define SIX_SPECIAL 6'h38
`define FOUR_SPECIAL 4'hc
`endif

// [rtl/quad_serdes_parallel_port.v]
// Four-channel double-edge parallel port with optional 8b/10b codec
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "serdes_port_defines.vh"

module quad_serdes_parallel_port #(
  parameter RX_HALF = `RX_CLK_PERIOD_NS / 2 / `CLK_PERIOD_NS
) (
  input wire clk,
  input wire rst,
  input wire codec_enable,
  input wire channel_sync_select,
  input wire tx_clock_chan_a,
  input wire tx_clock_chan_b,
  input wire tx_clock_chan_c,
  input wire tx_clock_chan_d,
  input wire [39:0] tx_parallel_bus,
  output reg rx_clock_chan_a,
  output reg rx_clock_chan_b,
  output reg rx_clock_chan_c,
  output reg rx_clock_chan_d,
  output reg [39:0] rx_parallel_bus,
  output reg [39:0] tx_code,
  output reg [3:0] tx_code_valid,
  input wire [39:0] rx_code,
  input wire [3:0] rx_code_valid,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [31:0] reg_rdata,
  output wire irq
);

  localparam integer HALF_LAST_W = RX_HALF - 1;
  localparam integer HALF_MID_W = RX_HALF / 2 - 1;
  localparam [7:0] HALF_LAST = HALF_LAST_W[7:0];
  localparam [7:0] HALF_MID = HALF_MID_W[7:0];

  ////////////////////////////////////////////////////////////////////////
  // Code tables and codec functions

  // Six-bit sub-block, minus form, abcdei with a at the top
  function [5:0] tbl6;
    input [4:0] x;
    begin
      case (x)
        5'd0: tbl6 = 6'h27;
        5'd1: tbl6 = 6'h1d;
        5'd2: tbl6 = 6'h2d;
        5'd3: tbl6 = 6'h31;
        5'd4: tbl6 = 6'h35;
        5'd5: tbl6 = 6'h29;
        5'd6: tbl6 = 6'h19;
        5'd7: tbl6 = 6'h38;
        5'd8: tbl6 = 6'h39;
        5'd9: tbl6 = 6'h25;
        5'd10: tbl6 = 6'h15;
        5'd11: tbl6 = 6'h34;
        5'd12: tbl6 = 6'h0d;
        5'd13: tbl6 = 6'h2c;
        5'd14: tbl6 = 6'h1c;
        5'd15: tbl6 = 6'h17;
        5'd16: tbl6 = 6'h1b;
        5'd17: tbl6 = 6'h23;
        5'd18: tbl6 = 6'h13;
        5'd19: tbl6 = 6'h32;
        5'd20: tbl6 = 6'h0b;
        5'd21: tbl6 = 6'h2a;
        5'd22: tbl6 = 6'h1a;
        5'd23: tbl6 = 6'h3a;
        5'd24: tbl6 = 6'h33;
        5'd25: tbl6 = 6'h26;
        5'd26: tbl6 = 6'h16;
        5'd27: tbl6 = 6'h36;
        5'd28: tbl6 = 6'h0e;
        5'd29: tbl6 = 6'h2e;
        5'd30: tbl6 = 6'h1e;
        default: tbl6 = 6'h2b;
      endcase
    end
  endfunction

  // Four-bit sub-block, minus form, fghj with f at the top
  function [3:0] tbl4;
    input [2:0] y;
    begin
      case (y)
        3'd0: tbl4 = 4'hb;
        3'd1: tbl4 = 4'h9;
        3'd2: tbl4 = 4'h5;
        3'd3: tbl4 = 4'hc;
        3'd4: tbl4 = 4'hd;
        3'd5: tbl4 = 4'ha;
        3'd6: tbl4 = 4'h6;
        default: tbl4 = 4'he;
      endcase
    end
  endfunction

  // Count of ones
  function [2:0] pop;
    input [5:0] v;
    integer i;
    begin
      pop = 3'd0;
      for (i = 0; i < 6; i = i + 1) begin
        pop = pop + {2'b00, v[i]};
      end
    end
  endfunction

  // Encode a byte; result is {disparity after, code}
  function [10:0] enc;
    input [7:0] d;
    input k;
    input rd;
    reg [5:0] s;
    reg [3:0] f;
    reg r;
    reg alt;
    reg kn;
    begin
      s = (k && d[4:0] == 5'd28) ? `K28_MINUS : tbl6(d[4:0]);
      if (rd && (pop(s) != 3'd3 || s == `SIX_SPECIAL)) s = ~s;
      r = rd ^ (pop(s) != 3'd3);
      alt = d[7:5] == 3'd7 && (k || (!r && (d[4:0] == 5'd17 || d[4:0] == 5'd18 || d[4:0] == 5'd20))
            || (r && (d[4:0] == 5'd11 || d[4:0] == 5'd13 || d[4:0] == 5'd14)));
      f = alt ? `ALT7_MINUS : tbl4(d[7:5]);
      kn = k && d[4:0] == 5'd28 && pop({2'b00, f}) == 3'd2 && d[7:5] != 3'd3;
      if (kn) f = ~f;
      if (r && (pop({2'b00, f}) != 3'd2 || f == `FOUR_SPECIAL || kn)) f = ~f;
      enc = {r ^ (pop({2'b00, f}) != 3'd2), s, f};
    end
  endfunction

  // Decode a code group; result is {disparity after, error, special, byte}
  function [10:0] dec;
    input [9:0] c;
    input rd;
    reg [5:0] six;
    reg [5:0] m;
    reg [3:0] fe;
    reg [3:0] f;
    reg [4:0] x;
    reg [2:0] y;
    reg [2:0] n6;
    reg [2:0] n4;
    reg ok6;
    reg ok4;
    reg k28;
    reg bad;
    reg r6;
    reg r4;
    reg kf;
    integer i;
    begin
      six = c[9:4];
      n6 = pop(six);
      x = 5'd0;
      y = 3'd0;
      ok6 = 1'b0;
      ok4 = 1'b0;
      for (i = 0; i < 32; i = i + 1) begin
        m = tbl6(i[4:0]);
        if (six == m || (six == ~m && (pop(m) != 3'd3 || m == `SIX_SPECIAL))) begin
          ok6 = 1'b1;
          x = i[4:0];
        end
      end
      k28 = six == `K28_MINUS || six == ~`K28_MINUS;
      if (k28) begin
        ok6 = 1'b1;
        x = 5'd28;
      end
      // Neutral special fours swap meaning in the plus form
      fe = (six == ~`K28_MINUS && pop({2'b00, c[3:0]}) == 3'd2) ? ~c[3:0] : c[3:0];
      n4 = pop({2'b00, c[3:0]});
      for (i = 0; i < 8; i = i + 1) begin
        f = tbl4(i[2:0]);
        if (fe == f || (fe == ~f && (pop({2'b00, f}) != 3'd2 || f == `FOUR_SPECIAL))) begin
          ok4 = 1'b1;
          y = i[2:0];
        end
      end
      kf = fe == `ALT7_MINUS || fe == ~`ALT7_MINUS;
      if (kf) begin
        ok4 = 1'b1;
        y = 3'd7;
      end
      bad = (n6 > 3'd3 && rd) || (n6 < 3'd3 && !rd) || (six == `SIX_SPECIAL && rd) || (six == ~`SIX_SPECIAL && !rd);
      r6 = (n6 == 3'd3) ? rd : (n6 > 3'd3);
      bad = bad || (n4 > 3'd2 && r6) || (n4 < 3'd2 && !r6);
      bad = bad || (c[3:0] == `FOUR_SPECIAL && r6) || (c[3:0] == ~`FOUR_SPECIAL && !r6);
      r4 = (n4 == 3'd2) ? r6 : (n4 > 3'd2);
      kf = k28 || (kf && (x == 5'd23 || x == 5'd27 || x == 5'd29 || x == 5'd30));
      dec = {r4, !ok6 || !ok4 || bad, kf, y, x};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  reg [1:0] mode_s1;
  reg [1:0] mode_s2;
  reg [3:0] tclk_s1;
  reg [3:0] tclk_s2;
  reg [3:0] tclk_s3;
  reg [39:0] tbus_s1;
  reg [39:0] tbus_s2;

  // Two flops on every mode and bus pin from the host; the clock pins get three below
  always @(posedge clk) begin
    if (rst) begin
      mode_s1 <= 2'h0;
      mode_s2 <= 2'h0;
      tbus_s1 <= 40'h0;
      tbus_s2 <= 40'h0;
    end else begin
      mode_s1 <= {channel_sync_select, codec_enable};
      mode_s2 <= mode_s1;
      tbus_s1 <= tx_parallel_bus;
      tbus_s2 <= tbus_s1;
    end
  end

  // Clock pins keep tracking in reset: no false edge on release
  always @(posedge clk) begin
    tclk_s1 <= {tx_clock_chan_d, tx_clock_chan_c, tx_clock_chan_b, tx_clock_chan_a};
    tclk_s2 <= tclk_s1;
    tclk_s3 <= tclk_s2;
  end

  wire codec_on = mode_s2[0];
  wire sync_sel = mode_s2[1];
  wire [3:0] tx_edge_raw = tclk_s2 ^ tclk_s3;
  wire [9:0] tx_bus_chan_a = tbus_s2[9:0];
  wire [3:0] special_char_generate = {tbus_s2[38], tbus_s2[28], tbus_s2[18], tbus_s2[8]};
  wire [3:0] tx_edge = sync_sel ? {4{tx_edge_raw[0]}} : tx_edge_raw;

  ////////////////////////////////////////////////////////////////////////
  // Transmit capture and encode

  reg [3:0] tx_rd;
  integer t;

  // One word per edge of the selected transmit clock
  always @(posedge clk) begin
    if (rst) begin
      tx_code <= 40'h0;
      tx_code_valid <= 4'h0;
      tx_rd <= 4'h0;
    end else begin
      tx_code_valid <= tx_edge;
      if (tx_edge[0]) begin
        if (codec_on) begin
          {tx_rd[0], tx_code[9:0]} <= enc(tx_bus_chan_a[7:0], special_char_generate[0], tx_rd[0]);
        end else begin
          tx_code[9:0] <= tx_bus_chan_a;
        end
      end
      for (t = 1; t < 4; t = t + 1) begin
        // bits 8 and 9 share the clock
        if (tx_edge[t]) begin
          if (codec_on) begin
            {tx_rd[t], tx_code[t*10 +: 10]} <= enc(tbus_s2[t*10 +: 8], special_char_generate[t], tx_rd[t]);
          end else begin
            tx_code[t*10 +: 10] <= tbus_s2[t*10 +: 10];
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive decode and double-edge output

  reg [3:0] rx_rd;
  reg [39:0] pend;
  reg [3:0] pend_full;
  reg [3:0] run;
  reg [7:0] cnt [0:3];
  reg [3:0] rclk;
  reg [3:0] own_upd;
  reg [3:0] upd;
  reg [3:0] tog;
  reg [3:0] ev_err;
  reg [3:0] ev_ovr;
  reg [43:0] dwords;
  integer c;
  integer ch;

  // Divider taps and per-lane decode: toggle at half period, data change mid-way
  always @* begin
    for (ch = 0; ch < 4; ch = ch + 1) begin
      own_upd[ch] = run[ch] && cnt[ch] == HALF_MID;
      tog[ch] = run[ch] && cnt[ch] == HALF_LAST;
      dwords[ch*11 +: 11] = dec(rx_code[ch*10 +: 10], rx_rd[ch]);
    end
    // B to D follow channel A
    // bits 8 and 9 take the same timing
    upd = sync_sel ? {4{own_upd[0]}} : own_upd;
  end

  // Decode, pend and present one word per receive clock edge
  always @(posedge clk) begin
    if (rst) begin
      rx_rd <= 4'h0;
      pend <= 40'h0;
      pend_full <= 4'h0;
      run <= 4'h0;
      rclk <= 4'h0;
      rx_parallel_bus <= 40'h0;
      ev_err <= 4'h0;
      ev_ovr <= 4'h0;
      for (c = 0; c < 4; c = c + 1) begin
        cnt[c] <= 8'h00;
      end
    end else begin
      for (c = 0; c < 4; c = c + 1) begin
        ev_err[c] <= 1'b0;
        ev_ovr[c] <= 1'b0;
        if (rx_code_valid[c]) begin
          run[c] <= 1'b1;
        end
        if (run[c]) begin
          cnt[c] <= tog[c] ? 8'h00 : cnt[c] + 8'h01;
        end
        // B to D clocks held low when synced
        if (c != 0 && sync_sel) begin
          rclk[c] <= 1'b0;
        end else if (tog[c]) begin
          rclk[c] <= ~rclk[c];
        end
        if (upd[c]) begin
          rx_parallel_bus[c*10 +: 10] <= pend[c*10 +: 10];
          pend_full[c] <= 1'b0;
        end
        if (rx_code_valid[c]) begin
          pend_full[c] <= 1'b1;
          ev_ovr[c] <= pend_full[c] && !upd[c];
          if (codec_on) begin
            rx_rd[c] <= dwords[c*11 + 10];
            pend[c*10 +: 10] <= dwords[c*11 +: 10];
            ev_err[c] <= dwords[c*11 + 9];
          end else begin
            pend[c*10 +: 10] <= rx_code[c*10 +: 10];
          end
        end
      end
    end
  end

  // Receive clock pins
  always @* begin
    rx_clock_chan_a = rclk[0];
    rx_clock_chan_b = rclk[1];
    rx_clock_chan_c = rclk[2];
    rx_clock_chan_d = rclk[3];
  end

  ////////////////////////////////////////////////////////////////////////
  // Register slave and interrupt

  reg [7:0] status;
  reg [7:0] irq_en;
  wire [7:0] clr = (reg_write && reg_addr == `REG_CLEAR) ? reg_wdata[7:0] : 8'h00;
  wire [7:0] events = {ev_ovr, ev_err};

  // Sticky status: a new event beats a clear
  always @(posedge clk) begin
    if (rst) begin
      status <= `STATUS_RESET;
      irq_en <= `IRQ_EN_RESET;
    end else begin
      status <= (status & ~clr) | events;
      if (reg_write && reg_addr == `REG_IRQ_EN) begin
        irq_en <= reg_wdata[7:0];
      end
    end
  end

  // Read data in the cycle after the strobe only
  always @(posedge clk) begin
    if (rst || !reg_read) begin
      reg_rdata <= 32'h0;
    end else begin
      case (reg_addr)
        `REG_STATUS: reg_rdata <= {24'h0, status};
        `REG_IRQ_EN: reg_rdata <= {24'h0, irq_en};
        `REG_MODE: reg_rdata <= {30'h0, sync_sel, codec_on};
        default: reg_rdata <= 32'h0;
      endcase
    end
  end

  assign irq = |(status & irq_en);

endmodule

`default_nettype wire

// [test/port_checker_assertions.sv]
// Concurrent checks on the parallel port pins
`timescale 1ns/1ns
`default_nettype none
module port_checker #(
  parameter RX_HALF = 6
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic codec_enable,
  input wire logic channel_sync_select,
  input wire logic rx_clock_chan_a,
  input wire logic rx_clock_chan_b,
  input wire logic rx_clock_chan_c,
  input wire logic rx_clock_chan_d,
  input wire logic [39:0] rx_parallel_bus,
  input wire logic [39:0] tx_parallel_bus,
  input wire logic [39:0] tx_code,
  input wire logic [3:0] tx_code_valid
);
  default clocking cb @(posedge clk); endclocking
  // Reset plus one cycle, so no $fell or $stable check compares against a sample taken in reset
  logic rst_q;
  default disable iff (rst || rst_q);
  int hi;
  // Cycles the channel A receive clock has stood high
  always @(posedge clk) begin
    hi <= (rst || !rx_clock_chan_a) ? 0 : hi + 1;
    rst_q <= rst;
  end
  ////////////////////////////////////////////////////////////////////////////
  rx_half_len_a: assert property ($fell(rx_clock_chan_a) |-> hi == RX_HALF)
    else $error("receive clock half period wrong");
  sync_clk_low_a: assert property (channel_sync_select && $past(channel_sync_select, 4) |->
    !rx_clock_chan_b && !rx_clock_chan_c && !rx_clock_chan_d) else $error("receive clock b-d not low");
  rx_a_centred_a: assert property (!$stable(rx_parallel_bus[9:0]) |-> $stable(rx_clock_chan_a))
    else $error("lane a changes on its clock edge");
  rx_b_own_a: assert property (!$stable(rx_parallel_bus[19:10]) && !channel_sync_select &&
    !$past(channel_sync_select, 4) |-> $stable(rx_clock_chan_b)) else $error("lane b changes on its clock edge");
  rx_d_on_a_a: assert property (!$stable(rx_parallel_bus[39:30]) && channel_sync_select &&
    $past(channel_sync_select, 4) |-> $stable(rx_clock_chan_a)) else $error("lane d changes on clock a edge");
  tx_raw_a: assert property (tx_code_valid[0] && !codec_enable && !$past(codec_enable, 6) |->
    tx_code[9:0] == $past(tx_parallel_bus[9:0], 2)) else $error("raw transmit word altered");
  tx_kchar_a: assert property (tx_code_valid[0] && codec_enable && $past(codec_enable, 6) &&
    $past(tx_parallel_bus[8:0], 2) == 9'h1bc |-> tx_code[9:0] inside {10'h0fa, 10'h305}) else $error("bad K code");
  tx_pulse_a: assert property (tx_code_valid[1] |=> !tx_code_valid[1] [*4])
    else $error("extra capture on lane b");
endmodule
bind quad_serdes_parallel_port port_checker #(.RX_HALF(RX_HALF)) port_checker_i (.clk, .rst, .codec_enable,
  .channel_sync_select, .rx_clock_chan_a, .rx_clock_chan_b, .rx_clock_chan_c, .rx_clock_chan_d,
  .rx_parallel_bus, .tx_parallel_bus, .tx_code, .tx_code_valid);
`default_nettype wire

// [test/host_model.sv]
// Parallel host driving the double-edge transmit clocks and words
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input wire logic [3:0] run,
  input wire logic [39:0] word,
  output logic [3:0] tx_clk,
  output logic [39:0] tx_bus
);
  initial begin
    tx_clk = 4'h0;
    tx_bus = 40'h0;
  end
  // data settle 4 ns before each edge, held 20 ns after
  always begin
    #20 tx_bus = |run ? word : ~tx_bus;
    #4 for (int c = 0; c < 4; c++) if (run[c] && tx_bus[c*10+:10] === word[c*10+:10]) tx_clk[c] = ~tx_clk[c];
  end
endmodule
`default_nettype wire

// [test/quad_serdes_parallel_port_tb.sv]
// Self-checking bench for the four-channel parallel port
`timescale 1ns/1ns
`default_nettype none
module quad_serdes_parallel_port_tb;
  typedef struct packed {logic cod; logic syn; logic [3:0] run; logic [9:0] tw, e0, e1, r0, r1, rm, re;} row_t;
  row_t rows[6];
  logic clk = 0, rst = 1, codec_enable = 0, channel_sync_select = 0, reg_write = 0, reg_read = 0, mon = 0;
  logic [3:0] run = 0, rx_code_valid = 0;
  logic [7:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0;
  logic [39:0] word = 0, rx_code = 0;
  logic [9:0] e0, e1;
  wire [39:0] tx_parallel_bus, tx_code, rx_parallel_bus;
  wire [31:0] reg_rdata;
  wire [3:0] tck, rck, txv;
  wire irq;
  int fails = 0, n_tests = 0, cnt[4];
  host_model host_model_i (.run(run), .word(word), .tx_clk(tck), .tx_bus(tx_parallel_bus));
  quad_serdes_parallel_port quad_serdes_parallel_port_i (.clk(clk), .rst(rst), .codec_enable(codec_enable),
    .channel_sync_select(channel_sync_select), .tx_clock_chan_a(tck[0]), .tx_clock_chan_b(tck[1]),
    .tx_clock_chan_c(tck[2]), .tx_clock_chan_d(tck[3]), .tx_parallel_bus(tx_parallel_bus),
    .rx_clock_chan_a(rck[0]), .rx_clock_chan_b(rck[1]), .rx_clock_chan_c(rck[2]), .rx_clock_chan_d(rck[3]),
    .rx_parallel_bus(rx_parallel_bus), .tx_code(tx_code), .tx_code_valid(txv), .rx_code(rx_code),
    .rx_code_valid(rx_code_valid), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq));
  // Clock, 4 ns period
  always #2 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1;
    @(posedge clk) reg_write <= 0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_read <= 1;
    @(posedge clk) reg_read <= 0;
    @(negedge clk) chk(reg_rdata, e);
    @(posedge clk);
  endtask
  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Captured transmit words per lane
  always @(posedge clk) begin
    for (int c = 0; c < 4; c++) if (mon && txv[c] === 1'b1) begin
      cnt[c]++;
      chk(tx_code[c*10+:10], cnt[c][0] ? e0 : e1);
    end
  end
  // Watchdog, about twenty times the expected run
  initial begin
    #100000 fails++;
    end_sim;
  end
  // Main sequence: table rows, then registers and reset
  initial begin
    rows = '{'{0, 0, 4'hf, 10'h3a5, 10'h3a5, 10'h3a5, 10'h155, 10'h155, 10'h3ff, 10'h155},
      '{0, 1, 4'h1, 10'h2c3, 10'h2c3, 10'h2c3, 10'h0fa, 10'h0fa, 10'h3ff, 10'h0fa},
      '{0, 0, 4'h1, 10'h1e1, 10'h1e1, 10'h1e1, 10'h2aa, 10'h2aa, 10'h3ff, 10'h2aa},
      '{1, 0, 4'hf, 10'h2b5, 10'h2aa, 10'h2aa, 10'h2aa, 10'h2aa, 10'h3ff, 10'h0b5},
      '{1, 1, 4'h1, 10'h1bc, 10'h0fa, 10'h305, 10'h0fa, 10'h305, 10'h3ff, 10'h1bc},
      '{1, 0, 4'hf, 10'h0b5, 10'h2aa, 10'h2aa, 10'h000, 10'h000, 10'h200, 10'h200}};
    cyc(16);
    rst <= 0;
    cyc(2);
    foreach (rows[i]) begin
      codec_enable <= rows[i].cod;
      channel_sync_select <= rows[i].syn;
      word <= {4{rows[i].tw}};
      e0 = rows[i].e0;
      e1 = rows[i].e1;
      cyc(12);
      cnt = '{default: 0};
      mon = 1;
      run <= rows[i].run;
      cyc(120);
      run <= 0;
      cyc(12);
      mon = 0;
      for (int c = 0; c < 4; c++) chk(cnt[c] > 0, rows[i].syn | rows[i].run[c]);
      for (int k = 0; k < 6; k++) begin
        rx_code <= {4{k[0] ? rows[i].r1 : rows[i].r0}};
        rx_code_valid <= 4'hf;
        cyc(1);
        rx_code_valid <= 0;
        cyc(5);
      end
      @(negedge clk);
      for (int c = 0; c < 4; c++) chk(rx_parallel_bus[c*10+:10] & rows[i].rm, rows[i].re);
      cyc(1);
    end
    rd(8'h00, 32'h0f);
    chk(irq, 0);
    wr(8'h08, 32'h01);
    chk(irq, 1);
    wr(8'h04, 32'h0f);
    chk(irq, 0);
    rd(8'h04, 32'h0);
    rd(8'h10, 32'h0);
    rd(8'h0c, 32'h1);
    rx_code <= {4{10'h2aa}};
    rx_code_valid <= 4'h1;
    cyc(3);
    rx_code_valid <= 0;
    cyc(4);
    rd(8'h00, 32'h10);
    chk(irq, 0);
    wr(8'h08, 32'h10);
    chk(irq, 1);
    rst <= 1;
    cyc(2);
    rst <= 0;
    cyc(1);
    @(negedge clk) chk({irq, rck, txv}, 9'h0);
    repeat (4) @(negedge clk) chk(txv, 4'h0);
    cyc(1);
    rd(8'h00, 32'h0);
    end_sim;
  end
endmodule
`default_nettype wire
